// >>> verif/iepr_irq_source_model.sv
`timescale 1ns/1ps
// peripheral flags and the core that takes a shown request one cycle after it is shown
module iepr_irq_source_model (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_nrst,
	// bench controls: set flags, handler clears
	input  wire logic [12:0] i_set,
	input  wire logic [12:0] i_sw_clr,
	// design side
	input  wire logic        i_valid,
	input  wire logic [12:0] i_flag_clear,
	output logic      [12:0] o_req,
	output logic             o_take
);
	// flags are levels until hardware or the handler clears them
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_req  <= 13'h0000;
			o_take <= 1'b0;
		end else begin
			o_req  <= (o_req | i_set) & ~i_flag_clear & ~i_sw_clr;
			o_take <= i_valid & ~o_take; // one pulse, never twice in a row
		end
	end
endmodule

// >>> verif/iepr_top_sva.sv
`timescale 1ns/1ps
// bus and vectoring relations seen at the top level ports
module iepr_top_sva #(
	parameter int N_SRC = 13
) (
	// clock and reset
	input wire logic             i_sys_clk,
	input wire logic             i_nrst,
	// bus
	input wire logic             i_wb_cyc,
	input wire logic             i_wb_stb,
	input wire logic             i_wb_we,
	input wire logic [9:0]       i_wb_adr,
	input wire logic [31:0]      o_wb_dat,
	input wire logic             o_wb_ack,
	// interrupt path
	input wire logic [1:0]       i_ext_edge_mode,
	input wire logic [N_SRC-1:0] i_irq_req,
	input wire logic             i_irq_take,
	input wire logic             o_irq_valid,
	input wire logic [15:0]      o_irq_vector,
	input wire logic [N_SRC-1:0] o_flag_clear
);
	// read answers by register index; adr is still held while ack is high
	wire rd_ack   = o_wb_ack && !i_wb_we;
	wire rd_bank1 = rd_ack && (i_wb_adr[9:2] inside {8'hB1, 8'hB2, 8'hB3});
	wire rd_prio0 = rd_ack && (i_wb_adr[9:2] inside {8'hB7, 8'hB8});
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	sequence s_req;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	sequence s_take;
		o_irq_valid && i_irq_take;
	endsequence
	a_ack_follows: assert property (s_req |=> o_wb_ack)
		else $error("ack missing after request");
	a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	a_dat_idle_zero: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
		else $error("read data outside an answer");
	a_bank1_reserved: assert property (rd_bank1 |-> !o_wb_dat[7] && !o_wb_dat[5])
		else $error("reserved bank 1 bit read one");
	a_prio0_bit7: assert property (rd_prio0 |-> !o_wb_dat[7])
		else $error("priority bank 0 bit 7 read one");
	a_valid_cause: assert property (o_irq_valid |-> $past(|i_irq_req))
		else $error("request shown with no flag");
	a_take_drops: assert property (s_take |=> !o_irq_valid)
		else $error("request still shown after take");
	a_clear_cause: assert property (|o_flag_clear |-> $past(o_irq_valid && i_irq_take))
		else $error("flag clear without a take");
	a_clear_hw_only: assert property (o_flag_clear[N_SRC-1:4] == '0)
		else $error("software flag cleared by hardware");
	a_vector_slots: assert property (o_irq_valid |-> o_irq_vector[2:0] == 3'h3 &&
		o_irq_vector <= 16'h006B && o_irq_vector != 16'h0063)
		else $error("vector outside the table");
	a_timer0_clear: assert property ((s_take and o_irq_vector == 16'h000B) |=> o_flag_clear[1])
		else $error("timer 0 flag not cleared");
	a_ext0_mode: assert property ((s_take and o_irq_vector == 16'h0003) |=>
		o_flag_clear[0] == $past(i_ext_edge_mode[0]))
		else $error("ext 0 clear ignores trigger mode");
endmodule

bind iepr_top iepr_top_sva #(.N_SRC(N_SRC)) iepr_top_sva_inst (
	.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
	.i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.i_ext_edge_mode(i_ext_edge_mode), .i_irq_req(i_irq_req), .i_irq_take(i_irq_take),
	.o_irq_valid(o_irq_valid), .o_irq_vector(o_irq_vector), .o_flag_clear(o_flag_clear)
);

// >>> verif/tb.sv
`timescale 1ns/1ps
// register rows first, then vectoring, preemption and a second reset
module tb;
	logic        clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ret = 1'b0;
	logic        take, ack, valid;
	logic [1:0]  lvl, edge_m = 2'h3;
	logic [3:0]  sel = 4'h0;
	logic [9:0]  adr = 10'h000;
	logic [12:0] req_set = 13'h0000, sw_clr = 13'h0000, req, fclr;
	logic [15:0] vec;
	logic [31:0] wdat = 32'h0, odat, rdat;
	int          n_fail = 0, checked = 0;
	// index, value written, value read back
	localparam logic [23:0] ROWS [7] = '{24'hA8FFFF, 24'hB1FF5F, 24'hB2FF5F, 24'hB3FF5F,
		24'hB7FF7F, 24'hB8FF7F, 24'hA9FF00};
	// 250 MHz core clock
	always #2 clk = ~clk;
	iepr_top iepr_top_inst (
		.i_sys_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(odat), .o_wb_ack(ack),
		.i_irq_req(req), .i_ext_edge_mode(edge_m), .i_irq_take(take), .i_irq_return(ret),
		.o_irq_valid(valid), .o_irq_vector(vec), .o_irq_level(lvl), .o_flag_clear(fclr)
	);
	iepr_irq_source_model iepr_irq_source_model_inst (
		.i_sys_clk(clk), .i_nrst(nrst), .i_set(req_set), .i_sw_clr(sw_clr),
		.i_valid(valid), .i_flag_clear(fclr), .o_req(req), .o_take(take)
	);
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
		input logic [3:0] s);
		@(posedge clk);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, idx, 2'b00, 24'h0, d, s};
		// no assumed latency: only the watchdog ends a lost answer
		while (ack !== 1'b1)
			@(posedge clk);
		check("ack", {31'h0, ack}, 32'h1);
		rdat = odat;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		wb(1'b0, idx, 8'h00, 4'hF);
		check($sformatf("reg %0h", idx), rdat, {24'h0, exp});
	endtask
	// raise flags, or end a handler: flag cleared well before the return pulse
	task automatic flags(input logic [12:0] set, input logic [12:0] clr, input logic r);
		@(posedge clk);
		{req_set, sw_clr} <= {set, clr};
		@(posedge clk);
		{req_set, sw_clr} <= 26'h0;
		@(posedge clk);
		ret <= r;
		@(posedge clk);
		ret <= 1'b0;
	endtask
	// on: wait for a shown request and compare it; off: nothing may be shown
	task automatic expect_irq(input logic on, input logic [15:0] v, input logic [1:0] l);
		int k;
		if (!on) begin
			repeat (4) @(posedge clk);
			check("valid", {31'h0, valid}, 32'h0);
		end else begin
			for (k = 0; k < 20 && valid !== 1'b1; k++)
				@(posedge clk);
			check("vector", {16'h0, vec}, {16'h0, v});
			check("level", {30'h0, lvl}, {30'h0, l});
		end
	endtask
	initial begin
		int src;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 7; i++) begin
			rd(ROWS[i][23:16], 8'h00);
			wb(1'b1, ROWS[i][23:16], ROWS[i][15:8], 4'hF);
			rd(ROWS[i][23:16], ROWS[i][7:0]);
			wb(1'b1, ROWS[i][23:16], 8'h00, 4'hF);
		end
		// no low byte lane, no write
		wb(1'b1, 8'hA8, 8'h55, 4'hE);
		rd(8'hA8, 8'h00);
		// closed gate blocks timer 0, opening it vectors and hardware clears the flag
		wb(1'b1, 8'hA8, 8'h7F, 4'hF);
		flags(13'h0002, 13'h0000, 1'b0);
		expect_irq(1'b0, 16'h0, 2'h0);
		wb(1'b1, 8'hA8, 8'hFF, 4'hF);
		expect_irq(1'b1, 16'h000B, 2'h0);
		expect_irq(1'b0, 16'h0, 2'h0);
		check("timer0 flag", {31'h0, req[1]}, 32'h0);
		flags(13'h0000, 13'h0000, 1'b1);
		// each bank 1 enable blocks when clear, passes when set; usb skips slot 12
		for (int i = 0; i < 6; i++) begin
			src = 7 + i;
			wb(1'b1, 8'hB1, 8'h00, 4'hF);
			flags(13'h0001 << src, 13'h0000, 1'b0);
			expect_irq(1'b0, 16'h0, 2'h0);
			wb(1'b1, 8'hB1, 8'h01 << ((i == 5) ? 6 : i), 4'hF);
			expect_irq(1'b1, 16'(3 + 8 * ((src == 12) ? 13 : src)), 2'h0);
			flags(13'h0000, 13'h0001 << src, 1'b1);
		end
		// serial at level 2, timer 1 at level 1, ext 0 at level 0 already running
		wb(1'b1, 8'hB7, 8'h10, 4'hF);
		wb(1'b1, 8'hB8, 8'h08, 4'hF);
		flags(13'h0001, 13'h0000, 1'b0);
		expect_irq(1'b1, 16'h0003, 2'h0);
		flags(13'h0018, 13'h0000, 1'b0);
		expect_irq(1'b1, 16'h0023, 2'h2);
		expect_irq(1'b0, 16'h0, 2'h0);
		flags(13'h0000, 13'h0010, 1'b1);
		expect_irq(1'b1, 16'h001B, 2'h1);
		flags(13'h0000, 13'h0000, 1'b1);
		flags(13'h0000, 13'h0000, 1'b1);
		// equal levels follow the polling order
		flags(13'h0006, 13'h0000, 1'b0);
		expect_irq(1'b1, 16'h000B, 2'h0);
		flags(13'h0000, 13'h0000, 1'b1);
		expect_irq(1'b1, 16'h0013, 2'h0);
		flags(13'h0000, 13'h0000, 1'b1);
		// level-mode ext 0 keeps its flag until the handler clears it
		edge_m <= 2'h2;
		flags(13'h0001, 13'h0000, 1'b0);
		expect_irq(1'b1, 16'h0003, 2'h0);
		expect_irq(1'b0, 16'h0, 2'h0);
		check("ext0 flag", {31'h0, req[0]}, 32'h1);
		flags(13'h0000, 13'h0001, 1'b1);
		edge_m <= 2'h3;
		// reset in mid-run drops what was written
		nrst <= 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		rd(8'hA8, 8'h00);
		rd(8'hB7, 8'h00);
		end_sim();
	end
	// the sequence needs under two thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		end_sim();
	end
endmodule

// >>> verilog/iepr_arbiter.sv
`timescale 1ns/1ps
// picks the pending source of highest level, lowest index within a level
module iepr_arbiter
	import iepr_pkg::*;
#(
	parameter int N_SRC = 13
) (
	// candidates
	input  wire logic [N_SRC-1:0]   i_pending,
	input  wire logic [2*N_SRC-1:0] i_levels,
	// choice
	output logic                    o_found,
	output logic [3:0]              o_index,
	output iepr_level_type          o_level
);

	// scan upward; only a strictly higher level displaces an earlier pick
	always_comb begin
		o_found = 1'b0;
		o_index = 4'h0;
		o_level = 2'h0;
		for (int i = 0; i < N_SRC; i++) begin
			if (i_pending[i] && (!o_found || i_levels[2*i +: 2] > o_level)) begin // R15
				o_found = 1'b1;
				o_index = 4'(i);
				o_level = i_levels[2*i +: 2];  // R14
			end
		end
	end

endmodule

// >>> verilog/iepr_cfg.svh
`ifndef IEPR_CFG_SVH
`define IEPR_CFG_SVH

// register indices; byte address on the bus is four times the index
`define IEPR_IDX_ENABLE_0     8'hA8
`define IEPR_IDX_ENABLE_1     8'hB1
`define IEPR_IDX_PRIO_LOW_1   8'hB2
`define IEPR_IDX_PRIO_HIGH_1  8'hB3
`define IEPR_IDX_PRIO_HIGH_0  8'hB7
`define IEPR_IDX_PRIO_LOW_0   8'hB8

// reset values
`define IEPR_RST_ENABLE       8'h00
`define IEPR_RST_PRIO         8'h00

// writable bit masks: bank 1 has bits 7 and 5 unused, bank 0 priority bit 7 unused
`define IEPR_MASK_ENABLE_0    8'hFF
`define IEPR_MASK_BANK_1      8'h5F
`define IEPR_MASK_PRIO_0      8'h7F

// field positions
`define IEPR_BIT_GLOBAL_GATE  7
`define IEPR_BIT_USB          6

// vector table: first vector and spacing in bytes
`define IEPR_VECTOR_BASE      16'h0003
`define IEPR_VECTOR_STEP      16'h0008

`endif

// >>> verilog/iepr_pkg.sv
package iepr_pkg;

	// two-bit priority level, 0 lowest and 3 highest
	typedef logic [1:0] iepr_level_type;

	// sources in fixed polling order, index 0 polled first
	typedef enum logic [3:0] {
		IEPR_SRC_EXT_PIN0  = 4'h0,
		IEPR_SRC_TIMER0    = 4'h1,
		IEPR_SRC_EXT_PIN1  = 4'h2,
		IEPR_SRC_TIMER1    = 4'h3,
		IEPR_SRC_SERIAL    = 4'h4,
		IEPR_SRC_DECODER   = 4'h5,
		IEPR_SRC_AUDIO     = 4'h6,
		IEPR_SRC_CARD      = 4'h7,
		IEPR_SRC_TWO_WIRE  = 4'h8,
		IEPR_SRC_SPI       = 4'h9,
		IEPR_SRC_CONVERTER = 4'hA,
		IEPR_SRC_KEYPAD    = 4'hB,
		IEPR_SRC_USB       = 4'hC
	} iepr_source_type;

endpackage

// >>> verilog/iepr_top.sv
`timescale 1ns/1ps
`include "iepr_cfg.svh"

// Behaviour
// R1 - The first enable register holds the global gate at bit 7 and audio, decoder, serial, timer 1, ext 1, timer 0, ext 0 enables at bits 6 to 0.
// R2 - The second enable register holds USB at 6, keypad at 4, converter at 3, SPI at 2, two-wire at 1 and card at 0, with bits 7 and 5 unused.
// R3 - The USB and keypad enables pass their source's request when one and block it when zero.
// R4 - The converter, SPI, two-wire and card enables pass their source's request when set and block it when clear.
// R5 - Unused bits 7 and 5 of the second enable and both second-bank priority registers read zero and software never writes them to one (the bench writes FFh).
// R6 - Bit 7 of the first priority registers is undefined on read and at reset, software must not set it (the bench writes FFh), and the other bits reset to zero.
// R7 - Both enable registers and the second high-priority register clear to zero on reset.
// R8 - The first high-priority register holds level MSBs for audio, decoder, serial, timer 1, ext 1, timer 0, ext 0 at bits 6 to 0.
// R9 - The second high-priority register holds level MSBs for USB at 6, keypad at 4, converter at 3, SPI at 2, two-wire at 1, card at 0.
// R10 - The first low-priority register holds level LSBs for audio, decoder, serial, timer 1, ext 1, timer 0, ext 0 at bits 6 to 0.
// R11 - The second low-priority register holds level LSBs for USB at 6, keypad at 4, converter at 3, SPI at 2, two-wire at 1, card at 0.
// R12 - With the global gate at zero no source interrupts; with it at one each source follows its own enable.
// R13 - A source's level is its MSB and LSB taken together, 0 lowest to 3 highest.
// R14 - A running handler is preempted only by a strictly higher level, and higher levels are served first.
// R15 - Equal levels resolve in the fixed polling order, vectors starting at 0003h with 8-byte spacing.
// R16 - Edge-mode external and timer request flags clear when vectored, all other flags are cleared by software.
module iepr_top
	import iepr_pkg::*;
#(
	parameter int N_SRC = 13
) (
	// clock and reset
	input  wire logic             i_sys_clk,
	input  wire logic             i_nrst,
	// wishbone slave
	input  wire logic             i_wb_cyc,
	input  wire logic             i_wb_stb,
	input  wire logic             i_wb_we,
	input  wire logic [9:0]       i_wb_adr,
	input  wire logic [3:0]       i_wb_sel,
	input  wire logic [31:0]      i_wb_dat,
	output logic      [31:0]      o_wb_dat,
	output logic                  o_wb_ack,
	// request flags from peripherals, polling order
	input  wire logic [N_SRC-1:0] i_irq_req,
	input  wire logic [1:0]       i_ext_edge_mode,
	// core handshake
	input  wire logic             i_irq_take,
	input  wire logic             i_irq_return,
	output logic                  o_irq_valid,
	output logic      [15:0]      o_irq_vector,
	output logic      [1:0]       o_irq_level,
	output logic      [N_SRC-1:0] o_flag_clear
);

	// reset release through two flops
	logic       rst_meta_reg;
	logic       rst_sync_n_reg;

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta_reg   <= 1'b0;
			rst_sync_n_reg <= 1'b0;
		end else begin
			rst_meta_reg   <= 1'b1;
			rst_sync_n_reg <= rst_meta_reg;
		end
	end

	// register bank
	logic [7:0]  enable_0_reg;
	logic [7:0]  enable_1_reg;
	logic [7:0]  prio_high_0_reg;
	logic [7:0]  prio_low_0_reg;
	logic [7:0]  prio_high_1_reg;
	logic [7:0]  prio_low_1_reg;
	logic [31:0] rdata_reg;
	logic        ack_reg;

	// bus decode; the index is the byte address divided by four
	wire  [7:0]  bus_index  = i_wb_adr[9:2];
	wire         bus_req    = i_wb_cyc && i_wb_stb && !ack_reg;
	wire         bus_wr     = bus_req && i_wb_we && i_wb_sel[0];
	wire  [7:0]  wbyte      = i_wb_dat[7:0];
	wire         hit_en_0   = bus_index == `IEPR_IDX_ENABLE_0;
	wire         hit_en_1   = bus_index == `IEPR_IDX_ENABLE_1;
	wire         hit_ph_0   = bus_index == `IEPR_IDX_PRIO_HIGH_0;
	wire         hit_pl_0   = bus_index == `IEPR_IDX_PRIO_LOW_0;
	wire         hit_ph_1   = bus_index == `IEPR_IDX_PRIO_HIGH_1;
	wire         hit_pl_1   = bus_index == `IEPR_IDX_PRIO_LOW_1;

	// readback mux; unmapped indices read zero, reserved bits read zero
	wire  [7:0]  rd_byte =
		hit_en_0 ? enable_0_reg :
		hit_en_1 ? (enable_1_reg & `IEPR_MASK_BANK_1) :   // R5
		hit_ph_0 ? (prio_high_0_reg & `IEPR_MASK_PRIO_0) : // R6
		hit_pl_0 ? (prio_low_0_reg & `IEPR_MASK_PRIO_0) :  // R6
		hit_ph_1 ? (prio_high_1_reg & `IEPR_MASK_BANK_1) : // R5
		hit_pl_1 ? (prio_low_1_reg & `IEPR_MASK_BANK_1) :  // R5
		8'h00;

	// one-wait-state ack: answer the edge after the request is seen, drop next
	always_ff @(posedge i_sys_clk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg   <= bus_req;
			rdata_reg <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// writes; unused bits are masked so a stray one never lands in them
	always_ff @(posedge i_sys_clk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			enable_0_reg    <= `IEPR_RST_ENABLE; // R7
			enable_1_reg    <= `IEPR_RST_ENABLE; // R7
			prio_high_0_reg <= `IEPR_RST_PRIO;   // R6
			prio_low_0_reg  <= `IEPR_RST_PRIO;   // R6
			prio_high_1_reg <= `IEPR_RST_PRIO;   // R7
			prio_low_1_reg  <= `IEPR_RST_PRIO;
		end else if (bus_wr) begin
			if (hit_en_0)
				enable_0_reg <= wbyte & `IEPR_MASK_ENABLE_0;     // R1
			if (hit_en_1)
				enable_1_reg <= wbyte & `IEPR_MASK_BANK_1;       // R2 R5
			if (hit_ph_0)
				prio_high_0_reg <= wbyte & `IEPR_MASK_PRIO_0;    // R8 R6
			if (hit_pl_0)
				prio_low_0_reg <= wbyte & `IEPR_MASK_PRIO_0;     // R10 R6
			if (hit_ph_1)
				prio_high_1_reg <= wbyte & `IEPR_MASK_BANK_1;    // R9 R5
			if (hit_pl_1)
				prio_low_1_reg <= wbyte & `IEPR_MASK_BANK_1;     // R11 R5
		end
	end

	// gather a bank-1 register into sources 7..12 (card .. USB), skipping bit 5
	function automatic logic [5:0] bank1_fields(input logic [7:0] r);
		bank1_fields = {r[`IEPR_BIT_USB], r[4:0]};
	endfunction

	// per-source enable, MSB and LSB in polling order
	wire  [N_SRC-1:0] src_enable = {bank1_fields(enable_1_reg), enable_0_reg[6:0]}; // R3 R4
	wire  [N_SRC-1:0] src_msb    = {bank1_fields(prio_high_1_reg), prio_high_0_reg[6:0]};
	wire  [N_SRC-1:0] src_lsb    = {bank1_fields(prio_low_1_reg), prio_low_0_reg[6:0]};
	wire              gate       = enable_0_reg[`IEPR_BIT_GLOBAL_GATE];

	// level of each source, MSB above LSB
	logic [2*N_SRC-1:0] src_levels;
	always_comb begin
		src_levels = '0;
		for (int i = 0; i < N_SRC; i++)
			src_levels[2*i +: 2] = {src_msb[i], src_lsb[i]}; // R13
	end

	// levels whose handlers are in progress, one bit per level
	logic [3:0] active_reg;

	// one above the highest level in progress; an empty set gives 0 and admits any request
	function automatic logic [2:0] top_active(input logic [3:0] act);
		top_active = 3'h0;
		for (int l = 0; l < 4; l++)
			if (act[l])
				top_active = 3'(l + 1);
	endfunction

	wire  [2:0] floor_lvl = top_active(active_reg);

	// requests that pass the global gate and their own enable
	wire  [N_SRC-1:0] pending = gate ? (i_irq_req & src_enable) : '0; // R12 R3 R4

	// only levels strictly above the one in progress may preempt
	logic [N_SRC-1:0] eligible;
	always_comb begin
		eligible = '0;
		for (int i = 0; i < N_SRC; i++)
			eligible[i] = pending[i] && ({1'b0, src_levels[2*i +: 2]} >= floor_lvl); // R14
	end

	logic           win_found;
	logic [3:0]     win_index;
	iepr_level_type win_level;

	iepr_arbiter #(
		.N_SRC    (N_SRC)
	) u_arbiter (
		.i_pending(eligible),
		.i_levels (src_levels),
		.o_found  (win_found),
		.o_index  (win_index),
		.o_level  (win_level)
	);

	// vector slot: USB sits past a reserved slot
	wire  [3:0]  win_slot = (win_index == IEPR_SRC_USB) ? 4'hD : win_index;
	wire  [15:0] win_vec  = `IEPR_VECTOR_BASE + {win_slot, 3'b000}; // R15

	// presented request, held index for the take
	logic [3:0]  shown_index_reg;
	logic        valid_reg;
	logic [15:0] vector_reg;
	logic [1:0]  level_reg;
	wire         take = i_irq_take && valid_reg;

	// the take uses the registered choice so the core sees exactly what it took
	always_ff @(posedge i_sys_clk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			valid_reg       <= 1'b0;
			vector_reg      <= 16'h0000;
			level_reg       <= 2'h0;
			shown_index_reg <= 4'h0;
		end else begin
			valid_reg       <= win_found && !take;
			vector_reg      <= win_vec;
			level_reg       <= win_level;
			shown_index_reg <= win_index;
		end
	end

	// return clears the top level in progress; a take in the same cycle still lands
	logic [3:0] active_next;
	always_comb begin
		active_next = active_reg;
		if (i_irq_return && floor_lvl != 3'h0)
			active_next[floor_lvl[1:0] - 2'h1] = 1'b0;
		if (take)
			active_next[level_reg] = 1'b1; // R14
	end

	// edge-mode externals and timers get their flag cleared when vectored
	wire        is_ext0  = shown_index_reg == IEPR_SRC_EXT_PIN0;
	wire        is_ext1  = shown_index_reg == IEPR_SRC_EXT_PIN1;
	wire        is_timer = shown_index_reg == IEPR_SRC_TIMER0 ||
	                       shown_index_reg == IEPR_SRC_TIMER1;
	wire        hw_clear = is_timer || (is_ext0 && i_ext_edge_mode[0]) ||
	                       (is_ext1 && i_ext_edge_mode[1]); // R16
	logic [N_SRC-1:0] clear_next;
	always_comb begin
		clear_next = '0;
		if (take && hw_clear)
			clear_next[shown_index_reg] = 1'b1; // R16
	end

	always_ff @(posedge i_sys_clk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			active_reg   <= 4'h0;
			o_flag_clear <= '0;
		end else begin
			active_reg   <= active_next;
			o_flag_clear <= clear_next;
		end
	end

	// outputs straight from flops
	assign o_wb_ack     = ack_reg;
	assign o_wb_dat     = rdata_reg;
	assign o_irq_valid  = valid_reg;
	assign o_irq_vector = vector_reg;
	assign o_irq_level  = level_reg;

endmodule
